// File: core/cctmr_pkg.sv
// package: constants for the clock comparator and cpu timer block
package cctmr_pkg;
    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int CCTMR_WORD_W = 64;
    localparam int CCTMR_CMP_HI = 63;   // doubleword bit 0
    localparam int CCTMR_CMP_LO = 12;   // doubleword bit 51
    localparam int CCTMR_SIGN_POS = 63;
    localparam int CCTMR_MCC_TMR_VALID = 46;
    localparam int CCTMR_MCC_CMP_VALID = 47;
    localparam int CCTMR_LOG_TMR_ADDR = 216;
    localparam int CCTMR_LOG_CMP_ADDR = 224;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [63:0] CCTMR_CMP_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] CCTMR_TMR_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] CCTMR_TMR_STEP = 64'h0000_0000_0000_1000;
    localparam int CCTMR_CLK_MHZ = 200;
    localparam int CCTMR_STEP_US = 1;
    localparam int CCTMR_STEP_CYC = CCTMR_CLK_MHZ * CCTMR_STEP_US;
    typedef enum logic [1:0] {CCTMR_RUN, CCTMR_WAIT, CCTMR_STOP} cctmr_mode_t;
endpackage

// File: core/cctmr_core.sv
// module: clock comparator, cpu timer, damage and logout values
`timescale 1ns/1ps
// Operation
// - comparator has tod format and clears on initial program reset
// - set-comparator loads the supplied value into the comparator
// - both masks set: request interruption while tod exceeds comparator
// - compare only doubleword bits 0 to 51
// - masked comparator condition pends only while tod stays above
// - store-comparator returns comparator contents unchanged
// - tod keeps stepping while stopped so comparator still fires
// - cpu timer is tod-format binary counter, bit 0 is sign
// - timer period equals the tod period, same resolution
// - timer decrements one unit every microsecond
// - timer and tod stepped from one common microsecond source
// - timer clears on reset; set loads, store returns its value
// - both masks set: request interruption whenever timer is negative
// - timer runs when executing or waiting, holds when stopped
// - setting a positive timer value clears pending timer request
// - comparator or timer facility error raises timing damage condition
// - damage gated by external damage mask and status word bit 13
// - supply timer and comparator values to machine-check logout
// - provide validity bits 46 and 47 for logged values
module cctmr_core
    import cctmr_pkg::*;
#(
    parameter int WORD_W = CCTMR_WORD_W
) (
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // system state
    input wire logic initial_program_reset_in,
    input wire cctmr_mode_t mode_in,
    input wire logic us_step_in,
    // time-of-day clock
    input wire logic [WORD_W-1:0] tod_value_in,
    // set/store operations
    input wire logic set_cmp_in,
    input wire logic set_tmr_in,
    input wire logic [WORD_W-1:0] set_data_in,
    input wire logic store_cmp_in,
    input wire logic store_tmr_in,
    output logic [WORD_W-1:0] store_data_out,
    output logic store_valid_out,
    // masks
    input wire logic ext_summary_mask_in,
    input wire logic cmp_subclass_mask_in,
    input wire logic tmr_subclass_mask_in,
    input wire logic damage_mask_in,
    input wire logic program_status_word_13_in,
    // facility errors
    input wire logic cmp_fault_in,
    input wire logic tmr_fault_in,
    // interruption requests
    output logic cmp_pending_out,
    output logic tmr_pending_out,
    output logic ext_irq_out,
    output logic damage_pending_out,
    output logic damage_irq_out,
    // machine-check logout
    input wire logic mchk_in,
    output logic [WORD_W-1:0] log_tmr_out,
    output logic [WORD_W-1:0] log_cmp_out,
    output logic log_tmr_valid_out,
    output logic log_cmp_valid_out,
    output logic log_strobe_out
);
    logic [WORD_W-1:0] cmp;
    logic [WORD_W-1:0] tmr;
    logic [WORD_W-1:0] next_tmr;
    logic tmr_counts;
    logic damage;

    // ------------------------------------------------------------
    // comparator register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmp <= CCTMR_CMP_RESET;
        end else if (clk_en_in) begin
            if (initial_program_reset_in) begin
                cmp <= CCTMR_CMP_RESET;
            end else if (set_cmp_in) begin
                cmp <= set_data_in;
            end
        end
    end

    // tod steps outside this block even when stopped; compare on each step
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmp_pending_out <= 1'b0;
        end else if (clk_en_in) begin
            if (initial_program_reset_in) begin
                cmp_pending_out <= 1'b0;
            end else if (us_step_in || set_cmp_in) begin
                // level condition, drops once tod no longer above
                cmp_pending_out <=
                    tod_value_in[CCTMR_CMP_HI:CCTMR_CMP_LO] >
                    (set_cmp_in ? set_data_in[CCTMR_CMP_HI:CCTMR_CMP_LO]
                                : cmp[CCTMR_CMP_HI:CCTMR_CMP_LO]);
            end
        end
    end

    // ------------------------------------------------------------
    // cpu timer
    // ------------------------------------------------------------
    // runs in run and wait, frozen when stopped
    assign tmr_counts = (mode_in != CCTMR_STOP) && us_step_in;
    // one unit is one microsecond at bit 51; same step as tod
    always_comb begin
        next_tmr = tmr;
        if (initial_program_reset_in) begin
            next_tmr = CCTMR_TMR_RESET;
        end else if (set_tmr_in) begin
            next_tmr = set_data_in;
        end else if (tmr_counts) begin
            next_tmr = tmr - CCTMR_TMR_STEP;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tmr <= CCTMR_TMR_RESET;
        end else if (clk_en_in) begin
            tmr <= next_tmr;
        end
    end

    // level: follows sign, so a positive set drops it at once
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tmr_pending_out <= 1'b0;
        end else if (clk_en_in) begin
            tmr_pending_out <= next_tmr[CCTMR_SIGN_POS];
        end
    end

    assign ext_irq_out = ext_summary_mask_in &
        ((cmp_subclass_mask_in & cmp_pending_out) |
         (tmr_subclass_mask_in & tmr_pending_out));

    // ------------------------------------------------------------
    // store path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            store_data_out <= '0;
            store_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            store_valid_out <= store_cmp_in | store_tmr_in;
            if (store_cmp_in) begin
                store_data_out <= cmp;
            end else if (store_tmr_in) begin
                store_data_out <= tmr;
            end
        end
    end

    // ------------------------------------------------------------
    // timing-facilities damage
    // ------------------------------------------------------------
    // sticky until initial program reset with no error present, since a live error wins; error sources are levels
    assign damage = cmp_fault_in | tmr_fault_in;
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            damage_pending_out <= 1'b0;
        end else if (clk_en_in) begin
            if (damage) begin
                damage_pending_out <= 1'b1;
            end else if (initial_program_reset_in) begin
                damage_pending_out <= 1'b0;
            end
        end
    end
    assign damage_irq_out = damage_pending_out & damage_mask_in &
        program_status_word_13_in;

    // ------------------------------------------------------------
    // machine-check logout values
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            log_tmr_out <= '0;
            log_cmp_out <= '0;
            log_tmr_valid_out <= 1'b0;
            log_cmp_valid_out <= 1'b0;
            log_strobe_out <= 1'b0;
        end else if (clk_en_in) begin
            log_strobe_out <= mchk_in;
            if (mchk_in) begin
                log_tmr_out <= tmr;
                log_cmp_out <= cmp;
                log_tmr_valid_out <= ~tmr_fault_in;
                log_cmp_valid_out <= ~cmp_fault_in;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_CMP_IPR: assert property (
        clk_en_in && initial_program_reset_in |=> cmp == CCTMR_CMP_RESET)
        else $error("comparator not cleared");
    AST_CMP_SET: assert property (
        clk_en_in && set_cmp_in && !initial_program_reset_in |=>
        cmp == $past(set_data_in))
        else $error("comparator not loaded");
    AST_CMP_HOLD: assert property (
        clk_en_in && !set_cmp_in && !initial_program_reset_in |=>
        $stable(cmp))
        else $error("comparator changed without set");
    AST_CMP_LVL: assert property (
        clk_en_in && us_step_in && !set_cmp_in &&
        !initial_program_reset_in |=> cmp_pending_out ==
        ($past(tod_value_in[CCTMR_CMP_HI:CCTMR_CMP_LO]) >
         $past(cmp[CCTMR_CMP_HI:CCTMR_CMP_LO])))
        else $error("comparator level wrong");
    AST_CMP_NEW: assert property (
        clk_en_in && set_cmp_in && !initial_program_reset_in |=>
        cmp_pending_out ==
        ($past(tod_value_in[CCTMR_CMP_HI:CCTMR_CMP_LO]) >
         $past(set_data_in[CCTMR_CMP_HI:CCTMR_CMP_LO])))
        else $error("comparator level after set wrong");
    AST_CMP_KEEP: assert property (
        clk_en_in && !us_step_in && !set_cmp_in &&
        !initial_program_reset_in |=> $stable(cmp_pending_out))
        else $error("comparator level moved between steps");

    AST_TMR_IPR: assert property (
        clk_en_in && initial_program_reset_in |=>
        tmr == CCTMR_TMR_RESET && !tmr_pending_out)
        else $error("timer not cleared");
    AST_TMR_DEC: assert property (
        clk_en_in && us_step_in && !set_tmr_in &&
        !initial_program_reset_in && mode_in != CCTMR_STOP |=>
        tmr == $past(tmr) - CCTMR_TMR_STEP)
        else $error("timer not decremented");
    AST_TMR_HOLD: assert property (
        clk_en_in && !us_step_in && !set_tmr_in &&
        !initial_program_reset_in |=> $stable(tmr))
        else $error("timer moved without a step");
    AST_TMR_STOP: assert property (
        clk_en_in && mode_in == CCTMR_STOP &&
        !set_tmr_in && !initial_program_reset_in |=> $stable(tmr))
        else $error("timer moved while stopped");
    AST_TMR_SET: assert property (
        clk_en_in && set_tmr_in &&
        !initial_program_reset_in |=> tmr == $past(set_data_in))
        else $error("set lost to step");
    AST_TMR_NEG: assert property (
        tmr_pending_out == tmr[CCTMR_SIGN_POS])
        else $error("timer pending not sign");
    AST_TMR_POS: assert property (
        clk_en_in && set_tmr_in && !set_data_in[CCTMR_SIGN_POS] &&
        !initial_program_reset_in |=> !tmr_pending_out)
        else $error("positive set kept pending");
    AST_FREEZE: assert property (
        !clk_en_in |=> $stable(tmr) && $stable(cmp) &&
        $stable(damage_pending_out))
        else $error("state moved with clock enable low");

    AST_EXT_IRQ: assert property (
        ext_irq_out |-> ext_summary_mask_in)
        else $error("irq without summary mask");
    AST_EXT_LVL: assert property (
        ext_irq_out == (ext_summary_mask_in &&
        ((cmp_subclass_mask_in && cmp_pending_out) ||
         (tmr_subclass_mask_in && tmr_pending_out))))
        else $error("external request level wrong");

    AST_DMG_GATE: assert property (
        damage_irq_out |-> damage_mask_in && program_status_word_13_in)
        else $error("damage not gated");
    AST_DMG_IRQ: assert property (
        damage_pending_out && damage_mask_in && program_status_word_13_in
        |-> damage_irq_out)
        else $error("damage not delivered");
    AST_DMG_SET: assert property (
        clk_en_in && damage |=> damage_pending_out)
        else $error("damage not raised");
    AST_DMG_HOLD: assert property (
        clk_en_in && damage_pending_out && !initial_program_reset_in |=>
        damage_pending_out)
        else $error("damage lost");

    AST_LOG: assert property (
        clk_en_in && mchk_in |=> log_strobe_out &&
        log_tmr_out == $past(tmr) && log_cmp_out == $past(cmp))
        else $error("logout values wrong");
    AST_LOG_ONE: assert property (
        clk_en_in && !mchk_in |=> !log_strobe_out)
        else $error("logout strobe too long");
    AST_LOG_VALID: assert property (
        clk_en_in && mchk_in |=>
        log_tmr_valid_out == !$past(tmr_fault_in) &&
        log_cmp_valid_out == !$past(cmp_fault_in))
        else $error("logout validity wrong");

    AST_STORE: assert property (
        clk_en_in && store_cmp_in |=>
        store_valid_out && store_data_out == $past(cmp))
        else $error("store comparator wrong");
    AST_STORE_TMR: assert property (
        clk_en_in && store_tmr_in && !store_cmp_in |=>
        store_valid_out && store_data_out == $past(tmr))
        else $error("store timer wrong");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    CV_CMP_FIRE: cover property (cmp_pending_out && ext_irq_out);
    CV_TMR_FIRE: cover property (tmr_pending_out && ext_irq_out);
    CV_TMR_CLEAR: cover property (tmr_pending_out ##1 !tmr_pending_out);
    CV_DAMAGE: cover property (damage_irq_out);
    CV_SET_STEP: cover property (clk_en_in && set_tmr_in && us_step_in);
endmodule

// File: verif/cctmr_tod_model.sv
// partner: time-of-day source with the shared microsecond step
`timescale 1ns/1ps
module cctmr_tod_model
    import cctmr_pkg::*;
#(
    parameter int PERIOD = 40,
    parameter logic [63:0] TOD_START = 64'h0000_0000_0000_0abc
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // step and time of day
    output logic us_step_out,
    output logic [63:0] tod_value_out
);
    int cnt = 0;
    initial begin
        us_step_out = 1'b0;
        tod_value_out = TOD_START;
    end
    // ------------------------------------------------------------
    // stepping
    // ------------------------------------------------------------
    // no mode input: tod keeps counting while the system is stopped
    // reset looked at on the edge, before the bench moves it
    always @(posedge ref_clk_in) begin
        if (rst_n_in) begin
            #1;
            cnt = (cnt + 1) % PERIOD;
            us_step_out = (cnt == 0);
            if (cnt == 0) begin
                tod_value_out = tod_value_out + CCTMR_TMR_STEP;
            end
        end
    end
endmodule

// File: verif/clock_comparator_cpu_timer_tb.sv
// testbench: set, store, step, mask, damage and logout scenarios
`timescale 1ns/1ps
module clock_comparator_cpu_timer_tb;
    import cctmr_pkg::*;
    localparam int P = 40;
    logic ref_clk_in = 0, rst_n_in = 0, initial_program_reset = 0, step;
    logic set_cmp = 0, set_tmr = 0, st_cmp = 0, st_tmr = 0, mchk = 0;
    logic en = 1;
    logic esm = 0, cmk = 0, tmk = 0, dmk = 0, psw13 = 0, cf = 0, tf = 0;
    logic sv, cp, tp, eirq, dp, dirq, ltv, lcv, ls;
    logic [63:0] tod, sd, lt, lc, data = 0;
    cctmr_mode_t mode = CCTMR_RUN;
    int num_errors = 0, checks_done = 0;
    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    cctmr_tod_model #(.PERIOD(P)) TOD (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .us_step_out(step), .tod_value_out(tod));
    cctmr_core DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(en), .initial_program_reset_in(initial_program_reset), .mode_in(mode),
        .us_step_in(step), .tod_value_in(tod), .set_cmp_in(set_cmp),
        .set_tmr_in(set_tmr), .set_data_in(data), .store_cmp_in(st_cmp),
        .store_tmr_in(st_tmr), .store_data_out(sd), .store_valid_out(sv),
        .ext_summary_mask_in(esm), .cmp_subclass_mask_in(cmk),
        .tmr_subclass_mask_in(tmk), .damage_mask_in(dmk),
        .program_status_word_13_in(psw13), .cmp_fault_in(cf),
        .tmr_fault_in(tf), .cmp_pending_out(cp), .tmr_pending_out(tp),
        .ext_irq_out(eirq), .damage_pending_out(dp), .damage_irq_out(dirq),
        .mchk_in(mchk), .log_tmr_out(lt), .log_cmp_out(lc),
        .log_tmr_valid_out(ltv), .log_cmp_valid_out(lcv),
        .log_strobe_out(ls));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wait_step();
        do
            @(posedge ref_clk_in);
        while (step !== 1'b1);
        #1;
    endtask
    // trailing idle cycle keeps back-to-back calls from re-driving a pulse
    task automatic set_val(input bit c, input logic [63:0] d);
        data = d;
        set_cmp = c;
        set_tmr = !c;
        tick(1);
        set_cmp = 0;
        set_tmr = 0;
        tick(1);
    endtask
    task automatic store_chk(input bit c, input logic [63:0] e);
        st_cmp = c;
        st_tmr = !c;
        tick(1);
        st_cmp = 0;
        st_tmr = 0;
        check(c ? "store cmp" : "store tmr", sd, e);
        check("store valid", sv, 1);
        tick(1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // clock, watchdog, tests
    // ------------------------------------------------------------
    always #2.5 ref_clk_in = ~ref_clk_in;
    initial begin
        #50000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        tick(2);
        rst_n_in = 1;
        store_chk(1, 64'h0);
        store_chk(0, 64'h0);
        set_val(1, 64'hffff_ffff_ffff_ffff);
        store_chk(1, 64'hffff_ffff_ffff_ffff);
        store_chk(1, 64'hffff_ffff_ffff_ffff);
        $display("test set store done");
        esm = 1;
        tmk = 1;
        wait_step();
        set_val(0, 64'h0000_0000_0000_1000);
        wait_step();
        store_chk(0, 64'h0);
        check("tmr pending", tp, 0);
        wait_step();
        tick(2);
        check("tmr pending", tp, 1);
        check("ext irq", eirq, 1);
        store_chk(0, 64'hffff_ffff_ffff_f000);
        mode = CCTMR_STOP;
        wait_step();
        store_chk(0, 64'hffff_ffff_ffff_f000);
        mode = CCTMR_WAIT;
        wait_step();
        store_chk(0, 64'hffff_ffff_ffff_e000);
        check("tmr pending", tp, 1);
        mode = CCTMR_RUN;
        set_val(0, 64'h0000_0000_0000_3000);
        tick(1);
        check("tmr pending", tp, 0);
        check("ext irq", eirq, 0);
        wait_step();
        tick(P - 1);
        set_val(0, 64'h0000_0000_0000_5000);
        store_chk(0, 64'h0000_0000_0000_5000);
        en = 0;
        wait_step();
        en = 1;
        store_chk(0, 64'h0000_0000_0000_5000);
        $display("test timer done");
        mode = CCTMR_STOP;
        wait_step();
        set_val(1, {tod[63:12], 12'h000});
        tick(1);
        check("cmp pending", cp, 0);
        cmk = 1;
        wait_step();
        tick(2);
        check("cmp pending", cp, 1);
        check("ext irq", eirq, 1);
        cmk = 0;
        tick(1);
        check("ext irq", eirq, 0);
        check("cmp pending", cp, 1);
        set_val(1, 64'hffff_ffff_ffff_ffff);
        tick(1);
        check("cmp pending", cp, 0);
        $display("test comparator done");
        dmk = 1;
        tf = 1;
        tick(2);
        check("damage", dp, 1);
        check("damage irq", dirq, 0);
        psw13 = 1;
        tick(1);
        check("damage irq", dirq, 1);
        mchk = 1;
        tick(1);
        mchk = 0;
        check("log strobe", ls, 1);
        check("log tmr", lt, 64'h0000_0000_0000_5000);
        check("log cmp", lc, 64'hffff_ffff_ffff_ffff);
        check("log tmr valid", ltv, 0);
        check("log cmp valid", lcv, 1);
        tf = 0;
        initial_program_reset = 1;
        tick(1);
        initial_program_reset = 0;
        tick(1);
        check("damage", dp, 0);
        store_chk(1, 64'h0);
        store_chk(0, 64'h0);
        $display("test damage logout done");
        report_and_stop();
    end
endmodule
